// ---- design/swf_regs.svh ----
// Constants of the switch forwarding-policy block
`ifndef SWF_REGS_SVH
`define SWF_REGS_SVH
// Static address entry field positions
`define SWF_SA_FID_MSB   57
`define SWF_SA_FID_LSB   54
`define SWF_SA_KEY_BY_FILTER_GROUP   53
`define SWF_SA_OVR       52
`define SWF_SA_VALID     51
`define SWF_SA_PORT_MSB  50
`define SWF_SA_PORT_LSB  48
`define SWF_SA_MAC_MSB   47
// VLAN entry field positions
`define SWF_VL_VALID     19
`define SWF_VL_MEM_MSB   18
`define SWF_VL_MEM_LSB   16
`define SWF_VL_FID_MSB   15
`define SWF_VL_FID_LSB   12
`define SWF_VL_VID_MSB   11
// Reset values
`define SWF_SA_RESET     58'h0
`define SWF_VL_RESET     20'hf0001
// Table sizes
`define SWF_N_STATIC     8
`define SWF_N_VLAN       16
// Frame classification
`define SWF_IPV4         4'h4
`define SWF_PROTO_IGMP   8'h02
`define SWF_BCAST_DA     48'hffffffffffff
`define SWF_MCAST_BIT    40
`define SWF_HOST_MAP     3'h4
`define SWF_ALL_MAP      3'h7
`define SWF_NONE_MAP     3'h0
// Rate settings
`define SWF_STEP_KBPS    32'd64
`define SWF_FINE_CODES   7'h0f
`define SWF_MBPS_KBPS    32'd1000
`define SWF_10BT_KBPS    32'd10000
`define SWF_10BT_MAX_CODE 7'd25
`define SWF_BITS_BYTE    32'd8
`define SWF_IFG_BYTES    20'h0000c
`define SWF_PRE_BYTES    20'h00008
// Rate window
`define SWF_WINDOW_NS    1000000
`define SWF_CLK_NS       10
`endif

// ---- design/swf_pkg.sv ----
// Types of the switch forwarding-policy block
package swf_pkg;
    typedef enum logic [1:0] {
        SWF_TBL_STATIC = 2'h1,
        SWF_TBL_VLAN   = 2'h2
    } swf_tbl_e;

    typedef struct packed {
        logic [1:0]  ingress;     // 0..2 = port 1..3
        logic [47:0] da;
        logic [11:0] vid;
        logic        is_ip;       // Ethernet IP or SNAP IP
        logic [3:0]  ip_ver;
        logic [7:0]  ip_proto;
        logic        err;
        logic [10:0] len;         // DA through FCS
    } swf_frm_s;

    typedef struct packed {
        logic [2:0]      tx_en;
        logic [2:0]      rx_en;
        logic [2:0]      rx_sniff;
        logic [2:0]      tx_sniff;
        logic [1:0]      sniffer;
        logic            mirror_both;
        logic            mirror_bad;
        logic            vlan_mode;
        logic            uu_drop;
        logic [2:0]      is_10bt;
        logic            cnt_ifg;
        logic            cnt_pre;
        logic            ing_all;
        logic [2:0]      ing_sel;    // mc, bc, flooded unicast
        logic [2:0][6:0] ing_rate;
        logic [2:0][6:0] eg_rate;
        logic            lb_far;
        logic            lb_far_origin; // 0 = PHY 1, 1 = PHY 2
        logic [1:0]      lb_near;
    } swf_cfg_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  port;
        logic [1:0]  prio;
        logic [10:0] len;
    } swf_txd_s;
endpackage

// ---- design/swf_forward.sv ----
// Forwarding decision, mirroring, rate limiting and loopback control
`include "swf_regs.svh"
module swf_forward #(
    parameter int WINDOW_CYCLES = `SWF_WINDOW_NS / `SWF_CLK_NS
) (
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              frm_valid_i,
    input  wire swf_pkg::swf_frm_s frm_i,
    input  wire logic              dyn_hit_i,
    input  wire logic [1:0]        dyn_port_i,
    input  wire swf_pkg::swf_cfg_s cfg_i,
    input  wire swf_pkg::swf_txd_s tx_done_i,
    input  wire logic              tbl_wr_i,
    input  wire logic              tbl_rd_i,
    input  wire swf_pkg::swf_tbl_e tbl_sel_i,
    input  wire logic [3:0]        tbl_addr_i,
    input  wire logic [57:0]       tbl_wdata_i,
    output logic [57:0]            tbl_rdata_o,
    output logic                   fwd_valid_o,
    output logic [2:0]             fwd_map_o,
    output logic                   drop_o,
    output logic                   learn_o,
    output logic [3:0]             learn_fid_o,
    output logic [2:0][3:0]        tx_permit_o,
    output logic [1:0]             pma_loop_o,
    output logic                   far_route_o
);
    localparam int N_Q = 12;

    logic [57:0]      static_reg [`SWF_N_STATIC];
    logic [19:0]      vlan_reg   [`SWF_N_VLAN];
    logic [31:0]      win_cnt_reg;
    logic             win_tick;
    logic [2:0][19:0] ing_cnt_reg;
    logic [19:0]      bkt_reg [N_Q];

    // Port number to one-hot map
    function automatic logic [2:0] port_bit(input logic [1:0] p);
        port_bit = 3'h1 << p;
    endfunction

    // Bytes allowed per window; zero means unlimited
    function automatic logic [19:0] rate_bytes(input logic [6:0] code, input logic is10);
        logic [31:0] kbps;
        kbps = 32'h0;
        if (code <= `SWF_FINE_CODES) begin
            kbps = {25'h0, code} * `SWF_STEP_KBPS;
        end else begin
            kbps = {25'h0, code - `SWF_FINE_CODES} * `SWF_MBPS_KBPS;
        end
        if (is10 && kbps > `SWF_10BT_KBPS) begin
            kbps = 32'h0;
        end
        rate_bytes = 20'(kbps / `SWF_BITS_BYTE);
    endfunction

    // Counted frame size
    function automatic logic [19:0] frame_bytes(input logic [10:0] len, input logic ifg, input logic pre);
        frame_bytes = {9'h0, len} + (ifg ? `SWF_IFG_BYTES : 20'h0)
                    + (pre ? `SWF_PRE_BYTES : 20'h0);
    endfunction

    // Table access from the management side; only it edits entries
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < `SWF_N_STATIC; i++) begin
                static_reg[i] <= `SWF_SA_RESET;
            end
            for (int i = 0; i < `SWF_N_VLAN; i++) begin
                vlan_reg[i] <= `SWF_VL_RESET;
            end
        end else if (tbl_wr_i) begin
            if (tbl_sel_i == swf_pkg::SWF_TBL_STATIC) begin
                static_reg[tbl_addr_i[2:0]] <= tbl_wdata_i;
            end else begin
                vlan_reg[tbl_addr_i] <= tbl_wdata_i[`SWF_VL_VALID:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tbl_rdata_o <= 58'h0;
        end else if (tbl_rd_i) begin
            tbl_rdata_o <= (tbl_sel_i == swf_pkg::SWF_TBL_STATIC) ? static_reg[tbl_addr_i[2:0]]
                                                                  : {38'h0, vlan_reg[tbl_addr_i]};
        end
    end

    // Rate window
    always_ff @(posedge clk_i) begin
        if (srst_i || win_tick) begin
            win_cnt_reg <= 32'h0;
        end else begin
            win_cnt_reg <= win_cnt_reg + 32'h1;
        end
    end
    assign win_tick = (win_cnt_reg == 32'(WINDOW_CYCLES - 1));

    // Lookup and policy
    logic        vlan_hit;
    logic [2:0]  vlan_mem;
    logic [3:0]  filter_group_id;
    logic        st_hit;
    logic [57:0] st_ent;
    logic        is_bcast;
    logic        is_mcast;
    logic        is_igmp;
    logic        uu_miss;
    logic        counted;
    logic [19:0] ing_lim;
    logic [19:0] fbytes;
    logic        rate_drop;
    logic [2:0]  base_map;
    logic [2:0]  map_next;
    logic        drop_next;
    logic        mirror;
    logic [2:0]  ing_bit;

    always_comb begin
        vlan_hit = 1'b0;
        vlan_mem = `SWF_ALL_MAP;
        filter_group_id      = 4'h0;
        if (cfg_i.vlan_mode) begin
            for (int i = 0; i < `SWF_N_VLAN; i++) begin
                if (!vlan_hit && vlan_reg[i][`SWF_VL_VALID]
                    && vlan_reg[i][`SWF_VL_VID_MSB:0] == frm_i.vid) begin
                    vlan_hit = 1'b1;
                    vlan_mem = vlan_reg[i][`SWF_VL_MEM_MSB:`SWF_VL_MEM_LSB];
                    filter_group_id      = vlan_reg[i][`SWF_VL_FID_MSB:`SWF_VL_FID_LSB];
                end
            end
        end
        st_hit = 1'b0;
        st_ent = 58'h0;
        for (int i = 0; i < `SWF_N_STATIC; i++) begin
            if (!st_hit && static_reg[i][`SWF_SA_VALID]
                && static_reg[i][`SWF_SA_MAC_MSB:0] == frm_i.da
                && (!static_reg[i][`SWF_SA_KEY_BY_FILTER_GROUP]
                    || static_reg[i][`SWF_SA_FID_MSB:`SWF_SA_FID_LSB] == filter_group_id)) begin
                st_hit = 1'b1;
                st_ent = static_reg[i];
            end
        end
    end

    always_comb begin
        ing_bit  = port_bit(frm_i.ingress);
        is_bcast = (frm_i.da == `SWF_BCAST_DA);
        is_mcast = frm_i.da[`SWF_MCAST_BIT] && !is_bcast;
        is_igmp  = frm_i.is_ip && frm_i.ip_ver == `SWF_IPV4 && frm_i.ip_proto == `SWF_PROTO_IGMP;
        uu_miss  = !st_hit && !dyn_hit_i && !frm_i.da[`SWF_MCAST_BIT];
        // Static result beats dynamic; dynamic covers DA only, SA goes out via learn
        if (is_igmp) begin
            base_map = `SWF_HOST_MAP;
        end else if (st_hit) begin
            base_map = (st_ent[`SWF_SA_PORT_MSB:`SWF_SA_PORT_LSB] == `SWF_ALL_MAP)
                     ? (`SWF_ALL_MAP & ~ing_bit)
                     : st_ent[`SWF_SA_PORT_MSB:`SWF_SA_PORT_LSB];
        end else if (dyn_hit_i) begin
            base_map = port_bit(dyn_port_i);
        end else if (uu_miss && cfg_i.uu_drop) begin
            base_map = `SWF_NONE_MAP;
        end else begin
            base_map = vlan_mem & ~ing_bit;
        end
        // Override bypasses the port enables
        if (!(st_hit && st_ent[`SWF_SA_OVR]) && !is_igmp) begin
            base_map = base_map & cfg_i.tx_en;
        end
        // Ingress categories and limit
        counted  = cfg_i.ing_all || (cfg_i.ing_sel[0] && is_mcast)
                || (cfg_i.ing_sel[1] && is_bcast) || (cfg_i.ing_sel[2] && uu_miss);
        ing_lim  = rate_bytes(cfg_i.ing_rate[frm_i.ingress], cfg_i.is_10bt[frm_i.ingress]);
        fbytes   = frame_bytes(frm_i.len, cfg_i.cnt_ifg, cfg_i.cnt_pre);
        rate_drop = counted && ing_lim != 20'h0
                 && (ing_cnt_reg[frm_i.ingress] + fbytes) > ing_lim;
        drop_next = rate_drop || frm_i.err
                 || (cfg_i.vlan_mode && !vlan_hit)
                 || (!cfg_i.rx_en[frm_i.ingress] && !(st_hit && st_ent[`SWF_SA_OVR]));
        if (drop_next) begin
            base_map = `SWF_NONE_MAP;
        end
        // Mirroring; several sniffed ports allowed, any sniffer port
        if (cfg_i.mirror_both) begin
            mirror = cfg_i.rx_sniff[frm_i.ingress] && |(base_map & cfg_i.tx_sniff);
        end else begin
            mirror = (cfg_i.rx_sniff[frm_i.ingress] && (!drop_next || (frm_i.err && cfg_i.mirror_bad)))
                  || |(base_map & cfg_i.tx_sniff);
        end
        map_next = base_map | (mirror ? port_bit(cfg_i.sniffer) : `SWF_NONE_MAP);
        // Far-end loopback sends traffic of the origin PHY to the wrapping PHY
        if (cfg_i.lb_far && frm_i.ingress == {1'b0, cfg_i.lb_far_origin}) begin
            map_next = port_bit({1'b0, ~cfg_i.lb_far_origin});
        end
    end

    // Ingress byte counters
    generate
        for (genvar p = 0; p < 3; p++) begin : g_ing
            always_ff @(posedge clk_i) begin
                if (srst_i || win_tick) begin
                    ing_cnt_reg[p] <= 20'h0;
                end else if (frm_valid_i && frm_i.ingress == 2'(p) && counted && !drop_next) begin
                    ing_cnt_reg[p] <= ing_cnt_reg[p] + fbytes;
                end
            end
        end
    endgenerate

    // Egress leaky buckets, one per port and priority
    generate
        for (genvar q = 0; q < N_Q; q++) begin : g_eg
            localparam logic [1:0] QP = 2'(q / 4);
            localparam logic [1:0] QR = 2'(q % 4);
            logic [19:0] lim;
            logic [19:0] lvl;
            assign lim = rate_bytes(cfg_i.eg_rate[QP], cfg_i.is_10bt[QP]);
            always_comb begin
                lvl = bkt_reg[q];
                if (win_tick) begin
                    lvl = (lvl > lim) ? lvl - lim : 20'h0;
                end
            end
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    bkt_reg[q] <= 20'h0;
                end else if (tx_done_i.valid && tx_done_i.port == QP && tx_done_i.prio == QR) begin
                    bkt_reg[q] <= lvl + frame_bytes(tx_done_i.len, cfg_i.cnt_ifg, cfg_i.cnt_pre);
                end else begin
                    bkt_reg[q] <= lvl;
                end
            end
            // Holding permit low stretches the gap until the bucket level falls below the limit
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    tx_permit_o[QP][QR] <= 1'b1;
                end else begin
                    tx_permit_o[QP][QR] <= (lim == 20'h0) || (lvl < lim);
                end
            end
        end
    endgenerate

    // Decision outputs, one cycle after the frame
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fwd_valid_o <= 1'b0;
            fwd_map_o   <= `SWF_NONE_MAP;
            drop_o      <= 1'b0;
            learn_o     <= 1'b0;
            learn_fid_o <= 4'h0;
        end else begin
            fwd_valid_o <= frm_valid_i;
            fwd_map_o   <= frm_valid_i ? map_next : `SWF_NONE_MAP;
            drop_o      <= frm_valid_i && map_next == `SWF_NONE_MAP;
            learn_o     <= frm_valid_i && !frm_i.err && !(cfg_i.vlan_mode && !vlan_hit);
            learn_fid_o <= filter_group_id;
        end
    end

    // Loopback controls; speed forcing is left to software
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pma_loop_o  <= 2'h0;
            far_route_o <= 1'b0;
        end else begin
            pma_loop_o  <= cfg_i.lb_near
                         | (cfg_i.lb_far ? {~cfg_i.lb_far_origin, cfg_i.lb_far_origin} : 2'h0);
            far_route_o <= cfg_i.lb_far;
        end
    end

    chk_igmp_host: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && is_igmp && !drop_next && !cfg_i.lb_far && cfg_i.rx_sniff == 3'h0
        && cfg_i.tx_sniff == 3'h0 |=> fwd_map_o == `SWF_HOST_MAP)
        else $error("IGMP frame not trapped to host port");
    chk_static_ports: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && st_hit && !is_igmp && !drop_next && !cfg_i.lb_far && st_ent[`SWF_SA_OVR]
        && cfg_i.rx_sniff == 3'h0 && cfg_i.tx_sniff == 3'h0
        |=> fwd_map_o == $past(base_map)
        && (fwd_map_o & ~$past(st_ent[`SWF_SA_PORT_MSB:`SWF_SA_PORT_LSB])) == 3'h0)
        else $error("Static entry ports not honoured");
    chk_rx_mirror: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && !cfg_i.mirror_both && !cfg_i.lb_far && cfg_i.rx_sniff[frm_i.ingress] && !drop_next
        |=> fwd_map_o[$past(cfg_i.sniffer)])
        else $error("Receive mirror copy missing");
    chk_both_mode: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && cfg_i.mirror_both && !cfg_i.rx_sniff[frm_i.ingress] && !cfg_i.lb_far
        |=> fwd_map_o == $past(base_map))
        else $error("Combined mirror without receive match");
    chk_uu_drop: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && uu_miss && cfg_i.uu_drop && !is_igmp && !cfg_i.lb_far && cfg_i.rx_sniff == 3'h0
        |=> drop_o && fwd_map_o == `SWF_NONE_MAP)
        else $error("Unknown unicast not dropped");
    chk_ingress_count: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && rate_drop |=> drop_o || $past(cfg_i.lb_far) || $past(cfg_i.rx_sniff) != 3'h0)
        else $error("Over-rate frame not dropped");
    chk_ten_unlimited: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_i.is_10bt[0] && cfg_i.eg_rate[0] > `SWF_10BT_MAX_CODE |=> ##1 tx_permit_o[0] == 4'hf)
        else $error("10BASE-T high rate still limited");
    chk_near_loop: assert property (@(posedge clk_i) disable iff (srst_i)
        cfg_i.lb_near[0] |=> pma_loop_o[0])
        else $error("Near-end loopback not applied");
    chk_no_ingress_back: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && st_hit && st_ent[`SWF_SA_PORT_MSB:`SWF_SA_PORT_LSB] == `SWF_ALL_MAP && !is_igmp
        && !cfg_i.lb_far && cfg_i.rx_sniff == 3'h0 && cfg_i.tx_sniff == 3'h0
        |=> (fwd_map_o & port_bit($past(frm_i.ingress))) == 3'h0)
        else $error("Flood entry returned frame to ingress");
    // Loopback path must bypass the lookup result entirely
    chk_far_wrap: assert property (@(posedge clk_i) disable iff (srst_i)
        frm_valid_i && cfg_i.lb_far && frm_i.ingress == {1'b0, cfg_i.lb_far_origin}
        |=> fwd_map_o == port_bit({1'b0, ~$past(cfg_i.lb_far_origin)}))
        else $error("Far-end loopback frame not sent to wrapping port");

    cov_igmp: cover property (@(posedge clk_i) frm_valid_i && is_igmp);
    cov_mirror_both: cover property (@(posedge clk_i) frm_valid_i && cfg_i.mirror_both && mirror);
    cov_rate_drop: cover property (@(posedge clk_i) frm_valid_i && rate_drop);
    cov_override: cover property (@(posedge clk_i) frm_valid_i && st_hit && st_ent[`SWF_SA_OVR]);
    cov_far_loop: cover property (@(posedge clk_i) frm_valid_i && cfg_i.lb_far);
endmodule // swf_forward

// ---- sim/swf_link_model.sv ----
// Behavioural link partner that reports as transmitted each forwarded frame that arrives while it is idle
module swf_link_model (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic         fwd_valid_i,
    input  wire logic [2:0]   fwd_map_i,
    input  wire logic [10:0]  len_i,
    input  wire logic         slow_i,
    output swf_pkg::swf_txd_s tx_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        busy_reg;
    logic [3:0]  wait_reg;
    logic [1:0]  port_reg;
    logic [10:0] len_reg;
    // One frame in flight; frames decided meanwhile are never reported
    always_ff @(posedge clk_i) begin
        tx_done_o <= '0;
        if (srst_i) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            wait_reg <= wait_reg - 4'h1;
            if (wait_reg == 4'h0) begin
                busy_reg <= 1'b0;
                tx_done_o <= '{1'b1, port_reg, 2'h0, len_reg};
            end
        end else if (fwd_valid_i && fwd_map_i != 3'h0) begin
            busy_reg <= 1'b1;
            wait_reg <= slow_i ? 4'h8 : 4'h0;
            port_reg <= fwd_map_i[0] ? 2'h0 : (fwd_map_i[1] ? 2'h1 : 2'h2);
            len_reg <= len_i;
        end
    end
endmodule // swf_link_model

// ---- sim/testbench.sv ----
// Self-checking testbench of the switch forwarding-policy block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MIRROR [6] = '{16'h210e, 16'h090e, 16'h050a, 16'h2b0e, 16'h2b21, 16'h6035};
    logic              clk_i = 1'b0;
    logic              srst_i = 1'b1;
    logic              fval = 1'b0;
    swf_pkg::swf_frm_s f = '0;
    logic              hit = 1'b0;
    logic [1:0]        dport = 2'h0;
    swf_pkg::swf_cfg_s cfg = '0;
    swf_pkg::swf_txd_s txd;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    swf_pkg::swf_tbl_e sel = swf_pkg::SWF_TBL_STATIC;
    logic [3:0]        addr = 4'h0;
    logic [57:0]       wdata = '0;
    logic [57:0]       rdata;
    logic              fv, drop, far;
    logic              learn;
    logic              slow = 1'b0;
    logic [2:0]        map;
    logic [3:0]        lfid;
    logic [2:0][3:0]   permit;
    logic [1:0]        loop;
    logic [15:0]       row;
    logic [1:0]        ing;
    int                mismatches = 0;
    int                compares = 0;
    int                cycles = 0;
    int                seed = 24;
    always #5 clk_i = ~clk_i;
    swf_forward #(.WINDOW_CYCLES(5000)) uut (.clk_i(clk_i), .srst_i(srst_i), .frm_valid_i(fval), .frm_i(f),
        .dyn_hit_i(hit), .dyn_port_i(dport), .cfg_i(cfg), .tx_done_i(txd), .tbl_wr_i(wr), .tbl_rd_i(rd),
        .tbl_sel_i(sel), .tbl_addr_i(addr), .tbl_wdata_i(wdata), .tbl_rdata_o(rdata), .fwd_valid_o(fv),
        .fwd_map_o(map), .drop_o(drop), .learn_o(learn), .learn_fid_o(lfid), .tx_permit_o(permit),
        .pma_loop_o(loop), .far_route_o(far));
    swf_link_model link (.clk_i(clk_i), .srst_i(srst_i), .fwd_valid_i(fv), .fwd_map_i(map), .len_i(f.len),
        .slow_i(slow), .tx_done_o(txd));
    function automatic swf_pkg::swf_frm_s frame(input logic [1:0] i, input logic [47:0] da, input logic [10:0] n);
        frame = '{i, da, 12'h001, 1'b0, 4'h0, 8'h00, 1'b0, n};
    endfunction
    function automatic swf_pkg::swf_cfg_s base();
        base = '0;
        base.tx_en = 3'h7;
        base.rx_en = 3'h7;
    endfunction
    // Bytes allowed per window; 10BASE-T above 10 Mbps means no limit
    function automatic int budget(input int code, input logic is10);
        if (code == 0 || (is10 && code > 25)) return 1 << 30;
        return (code <= 15) ? code * 64 / 8 : (code - 15) * 1000 / 8;
    endfunction
    task automatic end_of_test();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp_fwd(input logic [2:0] exp);
        compares++;
        if ({fv | drop, map, drop} !== {1'b1, exp, exp == 3'h0}) begin
            mismatches++;
            $display("Error at %0t: map %b drop %b, expected map %b", $time, map, drop, exp);
        end
    endtask
    task automatic cmp_val(input logic [57:0] got, input logic [57:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic h, input logic [1:0] dp, input logic [2:0] exp);
        @(negedge clk_i);
        fval = 1'b1;
        hit = h;
        dport = dp;
        @(negedge clk_i);
        fval = 1'b0;
        cmp_fwd(exp);
    endtask
    task automatic tbl(input logic w, input swf_pkg::swf_tbl_e s, input logic [3:0] a, input logic [57:0] d);
        @(negedge clk_i);
        wr = w;
        rd = !w;
        sel = s;
        addr = a;
        wdata = d;
        @(negedge clk_i);
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic do_reset();
        srst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        srst_i = 1'b0;
    endtask
    // Fresh reset so the rate window starts with the run
    task automatic rate_run(input int code, input logic is10, input logic opt, input int len);
        int sum;
        sum = 0;
        do_reset();
        cfg = base();
        cfg.ing_all = 1'b1;
        cfg.ing_rate[0] = 7'(code);
        cfg.is_10bt[0] = is10;
        cfg.cnt_ifg = opt;
        cfg.cnt_pre = opt;
        for (int k = 0; k < 4; k++) begin
            f = frame(2'h0, 48'h0000_0000_0a00, 11'(len));
            sum += len + (opt ? 20 : 0);
            send(1'b1, 2'h1, (sum <= budget(code, is10)) ? 3'h2 : 3'h0);
        end
        $display("Test rate code %0d finished", code);
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    initial begin
        cfg = base();
        do_reset();
        tbl(1'b0, swf_pkg::SWF_TBL_STATIC, 4'h0, '0);
        cmp_val(rdata, 58'h0);
        tbl(1'b0, swf_pkg::SWF_TBL_VLAN, 4'h0, '0);
        cmp_val(rdata, 58'hf0001);
        for (int k = 0; k < 16; k++) begin
            ing = 2'($unsigned($random(seed)) % 3);
            f = frame(ing, {16'($random(seed)) & 16'hfeff, 32'($random(seed))}, 11'd64);
            slow = $random(seed);
            send(1'b1, 2'((ing + 2'h1) % 3), 3'h1 << ((ing + 2'h1) % 3));
        end
        f = frame(2'h0, 48'h0000_0000_0e00, 11'd64);
        f.is_ip = 1'b1;
        f.ip_ver = 4'h4;
        f.ip_proto = 8'h02;
        send(1'b1, 2'h1, 3'h4);
        f.ip_ver = 4'h6;
        send(1'b1, 2'h1, 3'h2);
        f = frame(2'h0, 48'h0000_0000_0f00, 11'd64);
        send(1'b0, 2'h0, 3'h6);
        cfg.uu_drop = 1'b1;
        send(1'b0, 2'h0, 3'h0);
        $display("Test lookup finished");
        cfg = base();
        tbl(1'b1, swf_pkg::SWF_TBL_STATIC, 4'h1, 58'h00b01005e000001);
        tbl(1'b1, swf_pkg::SWF_TBL_STATIC, 4'h2, 58'h00a000000000c00);
        tbl(1'b1, swf_pkg::SWF_TBL_STATIC, 4'h3, 58'h00f01005e000002);
        f = frame(2'h2, 48'h0100_5e00_0001, 11'd64);
        send(1'b0, 2'h0, 3'h3);
        f = frame(2'h0, 48'h0000_0000_0c00, 11'd64);
        send(1'b1, 2'h2, 3'h2);
        cfg.rx_en[0] = 1'b0;
        send(1'b1, 2'h2, 3'h0);
        tbl(1'b1, swf_pkg::SWF_TBL_STATIC, 4'h2, 58'h01a000000000c00);
        send(1'b1, 2'h2, 3'h2);
        tbl(1'b0, swf_pkg::SWF_TBL_STATIC, 4'h2, '0);
        cmp_val(rdata, 58'h01a000000000c00);
        f = frame(2'h1, 48'h0100_5e00_0002, 11'd64);
        send(1'b0, 2'h0, 3'h5);
        $display("Test static table finished");
        for (int k = 0; k < 6; k++) begin
            row = MIRROR[k];
            cfg = base();
            cfg.rx_sniff = row[15:13];
            cfg.tx_sniff = row[12:10];
            cfg.mirror_both = row[9];
            cfg.sniffer = row[8:7];
            f = frame(row[6:5], 48'h0000_0000_0b00, 11'd64);
            send(1'b1, row[4:3], row[2:0]);
        end
        cfg = base();
        cfg.rx_sniff = 3'h1;
        cfg.sniffer = 2'h2;
        cfg.mirror_bad = 1'b1;
        f = frame(2'h0, 48'h0000_0000_0b00, 11'd64);
        f.err = 1'b1;
        send(1'b1, 2'h1, 3'h4);
        cfg.mirror_bad = 1'b0;
        send(1'b1, 2'h1, 3'h0);
        $display("Test mirroring finished");
        cfg = base();
        cfg.vlan_mode = 1'b1;
        tbl(1'b1, swf_pkg::SWF_TBL_VLAN, 4'h3, 58'hb5123);
        f = frame(2'h0, 48'h0000_0000_0d00, 11'd64);
        f.vid = 12'h123;
        send(1'b0, 2'h0, 3'h2);
        cmp_val(58'({learn, lfid}), 58'h15);
        f.vid = 12'h777;
        send(1'b0, 2'h0, 3'h0);
        cmp_val(58'(learn), 58'h0);
        $display("Test vlan finished");
        cfg = base();
        cfg.is_10bt = 3'h0;
        cfg.lb_near = 2'h1;
        repeat (2) @(negedge clk_i);
        cmp_val(58'({far, loop}), 58'h1);
        cfg.lb_near = 2'h0;
        cfg.lb_far = 1'b1;
        repeat (2) @(negedge clk_i);
        cmp_val(58'({far, loop}), 58'h6);
        f = frame(2'h0, 48'h0000_0000_0f00, 11'd64);
        send(1'b0, 2'h0, 3'h2);
        $display("Test loopback finished");
        rate_run(17, 1'b0, 1'b0, 64);
        rate_run(17, 1'b0, 1'b1, 64);
        rate_run(15, 1'b0, 1'b0, 62);
        rate_run(16, 1'b0, 1'b0, 62);
        rate_run(25, 1'b1, 1'b0, 1000);
        rate_run(26, 1'b1, 1'b0, 1000);
        cfg = base();
        cfg.ing_sel = 3'h2;
        cfg.ing_rate[0] = 7'h01;
        f = frame(2'h0, 48'h0000_0000_0a00, 11'd64);
        send(1'b1, 2'h1, 3'h2);
        f.da = 48'hffff_ffff_ffff;
        send(1'b0, 2'h0, 3'h0);
        do_reset();
        cfg = base();
        slow = 1'b0;
        cfg.eg_rate[1] = 7'h01;
        f = frame(2'h0, 48'h0000_0000_0a00, 11'd64);
        send(1'b1, 2'h1, 3'h2);
        repeat (12) @(negedge clk_i);
        cmp_val(58'(permit), 58'hfef);
        cfg.is_10bt = 3'h3;
        cfg.eg_rate[0] = 7'd26;
        cfg.eg_rate[1] = 7'd26;
        repeat (3) @(negedge clk_i);
        cmp_val(58'(permit), 58'hfff);
        $display("Test egress finished");
        end_of_test();
    end
endmodule // testbench
